// ### rtl/cfq_capture.sv
// Capture channels with two-deep FIFOs, quadrature decoder and AXI4-Lite registers.
// Operation
// - Each channel selects timer one or two; channels one and two share a choice.
// - Channel three has its own time-base select bit.
// - Inputs count only after holding a level across two clock edges.
// - Per channel, rising, falling or both edges trigger a capture.
// - Selected timer count is latched at the third clock edge after the input change.
// - Capture into a nonempty FIFO sets the flag; unmasked flag requests interrupt.
// - Reset clears control, status and FIFO registers.
// - Capture never disturbs timer counting or compare logic.
// - Each channel has a 16-bit, two-deep FIFO of top and bottom.
// - Top read returns oldest value and moves bottom up.
// - Bottom read turns status 10 or 11 into 01, and 01 into 00.
// - Capture into empty writes top, status 01; a read returns 00.
// - Second capture writes bottom, status 10; a read pops, status 01.
// - Third capture drops top, shifts bottom up, stores new, status 11.
// - Decoder enabled uses pins one and two and disables their capture.
// - Direction is up when input A leads, down when B leads.
// - One timer clock per edge of either encoder input.
// - Timer keeps counting from its present, possibly preloaded value.
// - Under decoder clocking the external direction and clock pins are ignored.
// - Decoder-clocked timer still raises period, underflow, overflow, compare flags.
// - Underflow at count 0000h, overflow at count FFFFh.
// - Flags clear by writing 1; requests stay blocked until cleared.
// - A flag with mask bit zero makes no interrupt request.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cfq_capture #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] sample_input_pin,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_two_count,
  input wire logic ext_direction_pin,
  input wire logic ext_timer_clock_pin,
  output logic [2:0] capture_irq,
  output logic timer_two_clock_pulse,
  output logic timer_two_count_up,
  output logic timer_two_underflow_hit,
  output logic timer_two_overflow_hit
);
  localparam int unsigned N = cfq_pkg::CHANNELS;
  localparam int unsigned W = cfq_pkg::DATA_W;

  logic [cfq_pkg::CTL_W-1:0] control_r;
  logic [N-1:0] flag_r;
  logic [N-1:0] mask_r;
  logic [2*N-1:0] status_r;
  logic [W-1:0] top_r [N];
  logic [W-1:0] bot_r [N];
  logic [N-1:0] pin_a_r;
  logic [N-1:0] pin_b_r;
  logic [N-1:0] level_r;
  logic [N-1:0] level_nxt;
  logic ext_clk_a_r;
  logic ext_clk_b_r;
  logic qep_dir_r;
  logic [15:0] t2_prev_r;

  // AXI state.
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_known;
  logic rd_known;
  logic [31:0] rd_val;

  // Handshakes and the write that fires once address and data are both held.
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Write decode; only the low byte lanes carry register bits.
  wire [ADDR_W-1:0] wa = {awaddr_r[ADDR_W-1:2], 2'b00};
  wire wr_ctl = wr_go && wa == ADDR_W'(cfq_pkg::OFF_CONTROL);
  wire wr_st = wr_go && wa == ADDR_W'(cfq_pkg::OFF_STATUS);
  wire wr_flg = wr_go && wa == ADDR_W'(cfq_pkg::OFF_FLAGS);
  wire wr_msk = wr_go && wa == ADDR_W'(cfq_pkg::OFF_MASK);
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wval = wdata_r & wmask;
  wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  // Control fields.
  wire qep_on = control_r[cfq_pkg::CTL_QEP_BIT];
  wire tb12 = control_r[cfq_pkg::CTL_TB12_BIT];
  wire tb3 = control_r[cfq_pkg::CTL_TB3_BIT];

  // Input qualification: a level is taken once two edges saw the same value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_a_r <= '0;
      pin_b_r <= '0;
      level_r <= '0;
      ext_clk_a_r <= 1'b0;
      ext_clk_b_r <= 1'b0;
    end else begin
      pin_a_r <= sample_input_pin;
      pin_b_r <= pin_a_r;
      level_r <= level_nxt;
      ext_clk_a_r <= ext_timer_clock_pin;
      ext_clk_b_r <= ext_clk_a_r;
    end
  end
  // The new level is taken once both stages agree, so a one-sample glitch is dropped.
  assign level_nxt = (pin_a_r ~^ pin_b_r) & pin_b_r | (pin_a_r ^ pin_b_r) & level_r;

  // Quadrature decoding of the two shared inputs.
  wire a_chg = level_nxt[0] ^ level_r[0];
  wire b_chg = level_nxt[1] ^ level_r[1];
  wire qep_step = qep_on && (a_chg ^ b_chg);
  // With one input moving, the relation of the pair after the move gives the direction.
  wire step_up = a_chg ? (level_nxt[0] != level_nxt[1]) : (level_nxt[0] == level_nxt[1]);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qep_dir_r <= 1'b0;
    end else if (qep_step) begin
      qep_dir_r <= step_up;
    end
  end

  // Timer two clock and direction source; timer count is left where it is.
  // The external clock counts on its rising edge only.
  wire ext_clk_rise = ext_clk_a_r && !ext_clk_b_r;
  assign timer_two_clock_pulse = qep_on ? qep_step : ext_clk_rise;
  assign timer_two_count_up = qep_on ? (qep_step ? step_up : qep_dir_r) : ext_direction_pin;

  // Count limit events, seen whichever source clocks the timer.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t2_prev_r <= '0;
    end else begin
      t2_prev_r <= timer_two_count;
    end
  end
  // A pulse marks the cycle in which the count has just arrived at a limit.
  wire t2_moved = t2_prev_r != timer_two_count;
  assign timer_two_underflow_hit = t2_moved && timer_two_count == cfq_pkg::CNT_MIN;
  assign timer_two_overflow_hit = t2_moved && timer_two_count == cfq_pkg::CNT_MAX;

  // Per-channel capture, FIFO and flag logic.
  logic [N-1:0] cap_hit;
  logic [N-1:0] top_rd;
  logic [N-1:0] bot_rd;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gch
      wire [1:0] esel = control_r[cfq_pkg::CTL_EDGE_LSB + 2*g +: 2];
      wire rise = level_nxt[g] && !level_r[g];
      wire fall = !level_nxt[g] && level_r[g];
      wire edge_ok = (rise && (esel == cfq_pkg::EDGE_RISE || esel == cfq_pkg::EDGE_BOTH))
                  || (fall && (esel == cfq_pkg::EDGE_FALL || esel == cfq_pkg::EDGE_BOTH));
      wire shared = (g < 2);
      wire pin_free = !(shared && qep_on);
      wire use_one = shared ? tb12 : tb3;
      wire [W-1:0] stamp = use_one ? timer_one_count : timer_two_count;
      wire [ADDR_W-1:0] top_adr = ADDR_W'(cfq_pkg::OFF_TOP0 + cfq_pkg::OFF_STEP * g);
      wire [ADDR_W-1:0] bot_adr = ADDR_W'(cfq_pkg::OFF_BOT0 + cfq_pkg::OFF_STEP * g);
      // Status seen by a capture: a software write, then any same-cycle read, apply first.
      wire [1:0] st_base = wr_st ? wval[2*g +: 2] : status_r[2*g +: 2];
      wire [1:0] st_read = top_rd[g] || bot_rd[g] ?
                           (st_base == cfq_pkg::ST_EMPTY ? cfq_pkg::ST_EMPTY :
                            st_base == cfq_pkg::ST_ONE ? cfq_pkg::ST_EMPTY :
                            cfq_pkg::ST_ONE) : st_base;
      wire [W-1:0] top_read = top_rd[g] && st_base[1] ? bot_r[g] : top_r[g];
      // Channels one and two stay idle while the decoder owns their pins.
      assign cap_hit[g] = control_r[cfq_pkg::CTL_EN_LSB + g] && pin_free && edge_ok;
      assign top_rd[g] = ar_fire && ra == top_adr;
      assign bot_rd[g] = ar_fire && ra == bot_adr;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          top_r[g] <= '0;
          bot_r[g] <= '0;
          status_r[2*g +: 2] <= cfq_pkg::ST_EMPTY;
        end else if (cap_hit[g]) begin
          unique case (st_read)
            cfq_pkg::ST_EMPTY: begin
              top_r[g] <= stamp;
              status_r[2*g +: 2] <= cfq_pkg::ST_ONE;
            end
            cfq_pkg::ST_ONE: begin
              top_r[g] <= top_read;
              bot_r[g] <= stamp;
              status_r[2*g +: 2] <= cfq_pkg::ST_TWO;
            end
            cfq_pkg::ST_TWO, cfq_pkg::ST_LOST: begin
              top_r[g] <= bot_r[g];
              bot_r[g] <= stamp;
              status_r[2*g +: 2] <= cfq_pkg::ST_LOST;
            end
          endcase
        end else begin
          top_r[g] <= top_read;
          status_r[2*g +: 2] <= st_read;
        end
      end
      // Flag set on capture into a nonempty FIFO; a set beats a same-cycle clear.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          flag_r[g] <= 1'b0;
        end else if (cap_hit[g] && status_r[2*g +: 2] != cfq_pkg::ST_EMPTY) begin
          flag_r[g] <= 1'b1;
        end else if (wr_flg && wval[g]) begin
          flag_r[g] <= 1'b0;
        end
      end
      assign capture_irq[g] = flag_r[g] && mask_r[g];
    end
  endgenerate

  // Control and mask registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_r <= '0;
      mask_r <= '0;
    end else begin
      if (wr_ctl) begin
        control_r <= wval[cfq_pkg::CTL_W-1:0];
      end
      if (wr_msk) begin
        mask_r <= wval[N-1:0];
      end
    end
  end

  // Write channel: address and data held in either order, then answered.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= cfq_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        // Unmapped addresses answer with an error; top and bottom writes are ignored.
        bresp_r <= wr_known ? cfq_pkg::RESP_OKAY : cfq_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read decode with zero above the register width.
  always_comb begin
    wr_known = wr_ctl || wr_st || wr_flg || wr_msk;
    rd_known = 1'b1;
    rd_val = '0;
    for (int i = 0; i < N; i++) begin
      if (wa == ADDR_W'(cfq_pkg::OFF_TOP0 + cfq_pkg::OFF_STEP * i)
          || wa == ADDR_W'(cfq_pkg::OFF_BOT0 + cfq_pkg::OFF_STEP * i)) begin
        wr_known = wr_go; // Top and bottom ignore writes.
      end
    end
    if (ra == ADDR_W'(cfq_pkg::OFF_CONTROL)) begin
      rd_val = 32'(control_r);
    end else if (ra == ADDR_W'(cfq_pkg::OFF_STATUS)) begin
      rd_val = 32'(status_r);
    end else if (ra == ADDR_W'(cfq_pkg::OFF_FLAGS)) begin
      rd_val = 32'(flag_r);
    end else if (ra == ADDR_W'(cfq_pkg::OFF_MASK)) begin
      rd_val = 32'(mask_r);
    end else begin
      rd_known = 1'b0;
      for (int i = 0; i < N; i++) begin
        if (top_rd[i] || ra == ADDR_W'(cfq_pkg::OFF_TOP0 + cfq_pkg::OFF_STEP * i)) begin
          rd_val = 32'(top_r[i]);
          rd_known = 1'b1;
        end
        if (ra == ADDR_W'(cfq_pkg::OFF_BOT0 + cfq_pkg::OFF_STEP * i)) begin
          rd_val = 32'(bot_r[i]);
          rd_known = 1'b1;
        end
      end
    end
  end

  // Read channel: one answer per address, held until taken.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= cfq_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      // FIFO side effects of this read happen at this same edge.
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_known ? cfq_pkg::RESP_OKAY : cfq_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/cfq_pkg.sv
// Package with register map, field positions and code values of the capture block.
package cfq_pkg;
  localparam int unsigned CHANNELS = 3;
  localparam int unsigned DATA_W = 16;
  // Register byte offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_TOP0 = 8'h10;
  localparam logic [7:0] OFF_BOT0 = 8'h1C;
  localparam logic [7:0] OFF_STEP = 8'h04;
  // Control register fields.
  localparam int unsigned CTL_EN_LSB = 0;
  localparam int unsigned CTL_QEP_BIT = 3;
  localparam int unsigned CTL_TB12_BIT = 4;
  localparam int unsigned CTL_TB3_BIT = 5;
  localparam int unsigned CTL_EDGE_LSB = 6;
  localparam int unsigned CTL_W = 12;
  // Edge select codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // FIFO status codes.
  localparam logic [1:0] ST_EMPTY = 2'h0;
  localparam logic [1:0] ST_ONE = 2'h1;
  localparam logic [1:0] ST_TWO = 2'h2;
  localparam logic [1:0] ST_LOST = 2'h3;
  // Counter limits.
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### test/cfq_capture_bench.sv
// Self-checking bench of the capture block driven through its register bus.
`timescale 1ns/1ps
`default_nettype none
module cfq_capture_bench;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, edir, eclk, tpls, tup, ufl, ofl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, wresp;
  logic [2:0] pin, irq;
  logic [15:0] t1, t2;
  int num_errors, comparisons, npls, nufl, nofl;
  cfq_src src (.clk(clk), .pin(pin));
  cfq_capture #(.ADDR_W(8)) DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_input_pin(pin), .timer_one_count(t1), .timer_two_count(t2),
    .ext_direction_pin(edir), .ext_timer_clock_pin(eclk), .capture_irq(irq),
    .timer_two_clock_pulse(tpls), .timer_two_count_up(tup),
    .timer_two_underflow_hit(ufl), .timer_two_overflow_hit(ofl));
  // Clock of 20 ns period.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counts one-cycle pulses at the falling edge, where they have settled.
  always @(negedge clk) begin
    if (tpls === 1'b1) npls++;
    if (ufl === 1'b1) nufl++;
    if (ofl === 1'b1) nofl++;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Register write: both channels offered together, each released once taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    ta = 0;
    tw = 0;
    tb = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      tb = bvalid;
      if (bvalid) wresp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  // Register read; the data are kept in got.
  task rc(input logic [7:0] a, input logic [31:0] e);
    bit ta, tr;
    ta = 0;
    tr = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = ta | (arvalid & arready);
      tr = rvalid;
      got = rdata;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    chk(got, e);
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the length of the sequence.
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
  // Main sequence.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, edir, eclk, nrst} = '0;
    {awaddr, araddr, wdata, t1, t2} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h28, 32'h0);
    chk(rresp, cfq_pkg::RESP_SLVERR);
    wr(8'h28, 32'h0);
    chk(wresp, cfq_pkg::RESP_SLVERR);
    wr(8'h04, 32'h0);
    chk(wresp, cfq_pkg::RESP_OKAY);
    t1 <= 16'h1111;
    t2 <= 16'hA001;
    wr(8'h00, 32'h0000_0E57);
    wr(8'h0C, 32'h7);
    src.put(3'h1, 3);
    src.put(3'h0, 3);
    src.put(3'h2, 3);
    rc(8'h04, 32'h1);
    src.put(3'h0, 3);
    t1 <= 16'h2222;
    src.put(3'h1, 3);
    rc(8'h04, 32'h6);
    chk(irq, 3'h1);
    rc(8'h10, 32'h1111);
    rc(8'h04, 32'h5);
    rc(8'h10, 32'h2222);
    rc(8'h14, 32'h1111);
    rc(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    rc(8'h08, 32'h0);
    chk(irq, 3'h0);
    // Three captures on the both-edge channel, timed by timer two.
    src.put(3'h5, 3);
    t2 <= 16'hA002;
    src.put(3'h1, 3);
    t2 <= 16'hA003;
    src.put(3'h5, 3);
    rc(8'h04, 32'h30);
    chk(irq, 3'h4);
    rc(8'h24, 32'hA003);
    rc(8'h04, 32'h10);
    rc(8'h18, 32'hA002);
    rc(8'h04, 32'h0);
    wr(8'h0C, 32'h3);
    chk(irq, 3'h0);
    src.put(3'h1, 0);
    src.put(3'h5, 3);
    rc(8'h04, 32'h0);
    // External clock, then the decoder on pins one and two.
    npls = 0;
    eclk <= 1'b1;
    repeat (4) @(posedge clk);
    chk(npls, 1);
    eclk <= 1'b0;
    src.put(3'h4, 3);
    wr(8'h00, 32'h0000_0E5F);
    repeat (4) src.qstep(1'b1);
    chk(npls, 5);
    chk(tup, 1'b1);
    rc(8'h04, 32'h0);
    repeat (4) src.qstep(1'b0);
    chk(npls, 9);
    chk(tup, 1'b0);
    edir <= 1'b1;
    eclk <= 1'b1;
    src.put(3'h7, 3);
    src.put(3'h4, 3);
    chk(npls, 9);
    chk(tup, 1'b0);
    t2 <= 16'h0000;
    repeat (3) @(posedge clk);
    t2 <= 16'hFFFF;
    repeat (3) @(posedge clk);
    chk(nufl, 1);
    chk(nofl, 1);
    close_out();
  end
endmodule
`default_nettype wire

// ### test/cfq_capture_chk.sv
// Checker of the capture block's port behaviour, bound into the design.
`timescale 1ns/1ps
`default_nettype none
module cfq_capture_chk #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [2:0] sample_input_pin,
  input wire logic [15:0] timer_two_count,
  input wire logic [2:0] capture_irq,
  input wire logic timer_two_clock_pulse,
  input wire logic timer_two_underflow_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bus handshakes hold and refuse as the slave promises.
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h28
    |=> s_axi_rresp == cfq_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // A request appears only from a qualified pin change or a register write.
  AST_FLAG_SET: assert property ($rose(capture_irq[0]) |-> $rose(s_axi_bvalid) ||
    ($past(sample_input_pin[0], 3) != $past(sample_input_pin[0], 4)))
    else $error("capture request without cause");
  AST_FLAG_CLR: assert property ($fell(capture_irq[0]) |-> $rose(s_axi_bvalid))
    else $error("capture request cleared without write");
  AST_UFL: assert property (timer_two_underflow_hit |-> timer_two_count == 16'h0000 &&
    $past(timer_two_count) != 16'h0000) else $error("underflow hit at wrong count");
  AST_PULSE: assert property (timer_two_clock_pulse |=> !timer_two_clock_pulse)
    else $error("timer clock pulse longer than one cycle");
  // Main scenarios seen at least once.
  COV_IRQ: cover property ($rose(capture_irq[2]));
  COV_PLS: cover property (timer_two_clock_pulse);
  COV_UFL: cover property (timer_two_underflow_hit);
endmodule
bind cfq_capture cfq_capture_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .nrst(nrst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .sample_input_pin(sample_input_pin),
  .timer_two_count(timer_two_count), .capture_irq(capture_irq),
  .timer_two_clock_pulse(timer_two_clock_pulse),
  .timer_two_underflow_hit(timer_two_underflow_hit));
`default_nettype wire

// ### test/cfq_src.sv
// Model of the external pulse sources and quadrature encoder on the capture pins.
`timescale 1ns/1ps
`default_nettype none
module cfq_src (
  input wire logic clk,
  output logic [2:0] pin
);
  logic [1:0] ph = 2'h0;
  // Encoder pattern {b, a}; stepping forward makes input a lead.
  logic [1:0] seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  initial pin = 3'h0;
  // Moves the pins just after an edge and holds them for n edges.
  task put(input logic [2:0] v, input int n);
    @(posedge clk);
    pin <= v;
    repeat (n) @(posedge clk);
  endtask
  // One quarter-period encoder step, long enough to be qualified.
  task qstep(input bit fwd);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    put({pin[2], seq[ph]}, 3);
  endtask
endmodule
`default_nettype wire
